// ===== logic/pla_pkg.sv
// Constants, register map and carrier types for the receive lane aligner.
package pla_pkg;

  localparam int LANES = 4;

  // One 66-bit block as delivered by a transceiver lane.
  typedef struct packed
  {
    logic        valid;
    logic [1:0]  header;
    logic [63:0] payload;
  } pla_blk_t;

  // Sync header and block type codes.
  localparam logic [1:0] HDR_DATA  = 2'h1;
  localparam logic [1:0] HDR_CTRL  = 2'h2;
  localparam logic [7:0] IDLE_TYPE = 8'h1E;

  // Lane marker identity bytes, one pattern per PCS lane.
  localparam logic [23:0] MARKER_PAT [LANES] =
    '{24'h90_76_47, 24'hF0_C4_E6, 24'hC5_65_9B, 24'hA2_79_3D};

  // Word lock, marker and counter limits.
  localparam logic [6:0]  LOCK_GOOD_CNT = 7'h40;
  localparam logic [4:0]  LOSE_BAD_CNT  = 5'h10;
  localparam logic [2:0]  REPEAT_LIMIT  = 3'h4;
  localparam logic [15:0] SPACING_RST   = 16'h3FFF;
  localparam logic [57:0] SCR_RST       = 58'h3FF_FFFF_FFFF_FFFF;

  // APB register byte addresses.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SPACING  = 8'h04;
  localparam logic [7:0] ADDR_LANESTAT = 8'h08;
  localparam logic [7:0] ADDR_IRQSTAT  = 8'h0C;
  localparam logic [7:0] ADDR_IRQEN    = 8'h10;
  localparam logic [7:0] ADDR_IRQCLR   = 8'h14;
  localparam logic [7:0] ADDR_LOOPSEL  = 8'h18;

  // Field positions.
  localparam int CTRL_TEST_BIT  = 0;
  localparam int CTRL_RLOOP_BIT = 1;
  localparam int IRQ_BIP_LSB    = 0;
  localparam int IRQ_INT_LSB    = 4;
  localparam int IRQ_REP_LSB    = 8;
  localparam int IRQ_FMT_BIT    = 12;
  localparam int IRQ_W          = 13;
  localparam int LOOPSEL_W      = 12;

endpackage

// ===== logic/pla_rx_lane_align.sv
// Receive lane alignment monitor, test pattern and loopback with APB access.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pla_rx_lane_align
(
  // Clock and reset
  input  wire  logic                                   clk,
  input  wire  logic                                   nrst,
  // APB slave
  input  wire  logic                                   psel,
  input  wire  logic                                   penable,
  input  wire  logic                                   pwrite,
  input  wire  logic [7:0]                             paddr,
  input  wire  logic [31:0]                            pwdata,
  output logic       [31:0]                            prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  output logic                                         irq,
  // Transceiver side
  input  wire  pla_pkg::pla_blk_t [pla_pkg::LANES-1:0] rxBlock,
  output pla_pkg::pla_blk_t [pla_pkg::LANES-1:0]       txOut,
  output logic [pla_pkg::LOOPSEL_W-1:0]                transceiverLoopbackSelect,
  // User side
  input  wire  pla_pkg::pla_blk_t [pla_pkg::LANES-1:0] txBlock,
  output logic [pla_pkg::LANES-1:0][1:0]               pcsLanePhysMap,
  output logic [pla_pkg::LANES-1:0]                    laneBipError,
  output logic [pla_pkg::LANES-1:0]                    laneSynced,
  output logic [pla_pkg::LANES-1:0]                    laneSyncError,
  output logic [pla_pkg::LANES-1:0]                    markerIntervalError,
  output logic [pla_pkg::LANES-1:0]                    markerRepeatError,
  output logic                                         markerFormatError
);
  import pla_pkg::*;

  // ********************************************************************
  // Registers and shared signals
  // ********************************************************************
  logic                 testReg;
  logic                 rloopReg;
  logic [15:0]          spacingReg;
  logic [IRQ_W-1:0]     irqStatReg;
  logic [IRQ_W-1:0]     irqEnReg;
  logic [IRQ_W-1:0]     irqSet;
  logic [IRQ_W-1:0]     irqClr;
  logic [LANES-1:0]     lockedReg;
  logic [LANES-1:0]     markerSeenReg;
  logic [LANES-1:0]     idValidReg;
  logic [LANES-1:0][1:0] laneIdReg;
  logic [LANES-1:0]     malformed;
  logic                 wrEn;
  logic                 accEn;

  function automatic logic [7:0] fold(input pla_blk_t b);
    logic [7:0] f;
    f = {6'h00, b.header};
    for (int k = 0; k < 8; k++)
      f = f ^ b.payload[8*k +: 8];
    return f;
  endfunction

  // Self-synchronous x^58 + x^39 + 1 scrambler, LSB first.
  function automatic logic [121:0] scramble(input logic [57:0] st,
                                            input logic [63:0] d);
    logic [57:0] s;
    logic [63:0] o;
    s = st;
    o = '0;
    for (int k = 0; k < 64; k++)
    begin
      o[k] = d[k] ^ s[38] ^ s[57];
      s    = {s[56:0], o[k]};
    end
    return {s, o};
  endfunction

  // ********************************************************************
  // Per physical lane monitor
  // ********************************************************************
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic [6:0]  goodCnt;
    logic [4:0]  badCnt;
    logic [15:0] gapCnt;
    logic [7:0]  bipAcc;
    logic [2:0]  repCnt;
    logic        hdrLost;
    logic        hdrOk;
    logic        cand;
    logic        goodMk;
    logic        gapBad;
    logic        mkErr;
    logic [1:0]  matchId;
    logic [57:0] scrSt;
    logic [121:0] scrOut;
    pla_blk_t    b;

    always_comb
    begin
      b       = rxBlock[i];
      hdrOk   = (b.header == HDR_DATA) || (b.header == HDR_CTRL);
      cand    = 1'b0;
      matchId = 2'h0;
      for (int p = 0; p < LANES; p++)
        if (b.payload[23:0] == MARKER_PAT[p])
        begin
          cand    = 1'b1;
          matchId = 2'(p);
        end
      cand = cand && b.valid && lockedReg[i] && (b.header == HDR_CTRL);
      malformed[i] = cand && ((b.payload[55:32] != ~b.payload[23:0]) ||
                              (b.payload[63:56] != ~b.payload[31:24]));
      goodMk = cand && !malformed[i];
      gapBad = goodMk && markerSeenReg[i] && (gapCnt != spacingReg);
      mkErr  = gapBad || malformed[i];
    end

    // Word boundary lock from sync headers.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        goodCnt      <= '0;
        badCnt       <= '0;
        lockedReg[i] <= 1'b0;
        hdrLost      <= 1'b0;
      end
      else if (b.valid)
      begin
        goodCnt <= hdrOk ? ((goodCnt == LOCK_GOOD_CNT) ? goodCnt
                                                       : goodCnt + 7'h01)
                         : '0;
        badCnt  <= hdrOk ? '0 : badCnt + 5'h01;
        if (!lockedReg[i] && hdrOk && goodCnt == LOCK_GOOD_CNT - 7'h01)
          lockedReg[i] <= 1'b1;
        if (lockedReg[i] && !hdrOk && badCnt == LOSE_BAD_CNT - 5'h01)
        begin
          lockedReg[i] <= 1'b0;
          hdrLost      <= 1'b1;
        end
        else if (laneSynced[i])
          hdrLost <= 1'b0;
      end
    end

    // Marker tracking, spacing count, identity and BIP8 check.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        markerSeenReg[i]       <= 1'b0;
        idValidReg[i]          <= 1'b0;
        laneIdReg[i]           <= 2'h0;
        gapCnt                 <= '0;
        bipAcc                 <= '0;
        laneBipError[i]        <= 1'b0;
        markerIntervalError[i] <= 1'b0;
      end
      else
      begin
        laneBipError[i]        <= goodMk && markerSeenReg[i] &&
                                  (bipAcc != b.payload[31:24]);
        markerIntervalError[i] <= gapBad;
        if (!lockedReg[i])
        begin
          markerSeenReg[i] <= 1'b0;
          idValidReg[i]    <= 1'b0;
          gapCnt           <= '0;
        end
        else if (goodMk)
        begin
          markerSeenReg[i] <= 1'b1;
          idValidReg[i]    <= 1'b1;
          laneIdReg[i]     <= matchId;
          gapCnt           <= '0;
          bipAcc           <= fold(b);
        end
        else if (b.valid)
        begin
          gapCnt <= (gapCnt == 16'hFFFF) ? gapCnt : gapCnt + 16'h0001;
          bipAcc <= bipAcc ^ fold(b);
        end
      end
    end

    // Lane status levels and marker repeat counting.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        laneSynced[i]        <= 1'b0;
        laneSyncError[i]     <= 1'b0;
        repCnt               <= '0;
        markerRepeatError[i] <= 1'b0;
      end
      else
      begin
        laneSynced[i]    <= lockedReg[i] && (markerSeenReg[i] || goodMk);
        laneSyncError[i] <= !laneSynced[i] && (hdrLost ||
                            (lockedReg[i] && !markerSeenReg[i] &&
                             gapCnt > spacingReg));
        markerRepeatError[i] <= mkErr && (repCnt == REPEAT_LIMIT - 3'h1);
        if (!lockedReg[i] || goodMk && !gapBad)
          repCnt <= '0;
        else if (mkErr)
          repCnt <= (repCnt == REPEAT_LIMIT - 3'h1) ? '0 : repCnt + 3'h1;
      end
    end

    assign scrOut = scramble(scrSt, {56'h0, IDLE_TYPE});
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        scrSt    <= SCR_RST;
        txOut[i] <= '0;
      end
      else if (rloopReg)
        txOut[i] <= rxBlock[i];
      else if (testReg)
      begin
        scrSt    <= scrOut[121:64];
        txOut[i] <= '{valid: 1'b1, header: HDR_CTRL,
                      payload: scrOut[63:0]};
      end
      else
        txOut[i] <= txBlock[i];
    end

    bipPulse_a: assert property (@(posedge clk) disable iff (!nrst)
      laneBipError[i] |=> !laneBipError[i])
      else $error("BIP error pulse longer than one cycle");

    sequence s_lockMark;
      lockedReg[i] ##1 (lockedReg[i] && markerSeenReg[i]);
    endsequence
    syncLevel_a: assert property (@(posedge clk) disable iff (!nrst)
      s_lockMark |=> laneSynced[i])
      else $error("Synced not raised after lock and marker");

    gapError_a: assert property (@(posedge clk) disable iff (!nrst)
      (goodMk && markerSeenReg[i] && gapCnt != spacingReg)
      |=> markerIntervalError[i])
      else $error("Marker spacing error missed");

    repeatErr_a: assert property (@(posedge clk) disable iff (!nrst)
      markerRepeatError[i] |-> $past(repCnt) == REPEAT_LIMIT - 3'h1)
      else $error("Repeat error without four marker errors");

    syncErr_a: assert property (@(posedge clk) disable iff (!nrst)
      laneSyncError[i] |-> !$past(laneSynced[i]))
      else $error("Sync error while lane synced");
  end

  // ********************************************************************
  // Lane map and format error
  // ********************************************************************
  // cleared in reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pcsLanePhysMap    <= '0;
      markerFormatError <= 1'b0;
    end
    else
    begin
      markerFormatError <= |malformed;
      for (int i = 0; i < LANES; i++)
        if (idValidReg[i] && lockedReg[i])
          pcsLanePhysMap[laneIdReg[i]] <= 2'(i);
    end
  end

  formatErr_a: assert property (@(posedge clk) disable iff (!nrst)
    (|malformed) |=> markerFormatError)
    else $error("Malformed marker not flagged");

  laneMap_a: assert property (@(posedge clk) disable iff (!nrst)
    (idValidReg[2] && lockedReg[2] && laneIdReg[2] != laneIdReg[3])
    |=> pcsLanePhysMap[$past(laneIdReg[2])] == 2'h2)
    else $error("Lane map does not follow marker identity");

  testIdle_a: assert property (@(posedge clk) disable iff (!nrst)
    (testReg && !rloopReg) |=> (txOut[0].header == HDR_CTRL))
    else $error("Test pattern not sending control blocks");

  // ********************************************************************
  // Interrupt status
  // ********************************************************************
  assign irqSet = {markerFormatError, markerRepeatError,
                   markerIntervalError, laneBipError};
  assign irqClr = (wrEn && paddr == ADDR_IRQCLR) ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqStatReg <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle.
      irqStatReg <= (irqStatReg & ~irqClr) | irqSet;
      irq        <= |(irqStatReg & irqEnReg);
    end
  end

  irqOut_a: assert property (@(posedge clk) disable iff (!nrst)
    (|(irqStatReg & irqEnReg)) |=> irq)
    else $error("Interrupt not raised for enabled status");

  // ********************************************************************
  // APB slave
  // ********************************************************************
  // The answer is decoded in the first access cycle so prdata leaves a flop.
  // A write lands only at the edge where the master sees pready, so an
  // abandoned transfer never changes a register.
  assign accEn = psel && penable && !pready;
  assign wrEn  = psel && penable && pwrite && pready;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      testReg                   <= 1'b0;
      rloopReg                  <= 1'b0;
      spacingReg                <= SPACING_RST;
      irqEnReg                  <= '0;
      transceiverLoopbackSelect <= '0;
    end
    else if (wrEn)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          testReg  <= pwdata[CTRL_TEST_BIT];
          rloopReg <= pwdata[CTRL_RLOOP_BIT];
        end
        ADDR_SPACING: spacingReg <= pwdata[15:0];
        ADDR_IRQEN:   irqEnReg   <= pwdata[IRQ_W-1:0];
        ADDR_LOOPSEL: transceiverLoopbackSelect <= pwdata[LOOPSEL_W-1:0];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= accEn;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (accEn)
      begin
        case (paddr)
          ADDR_CTRL:     prdata <= {30'h0, rloopReg, testReg};
          ADDR_SPACING:  prdata <= {16'h0, spacingReg};
          ADDR_LANESTAT: prdata <= {12'h0, lockedReg, pcsLanePhysMap,
                                    laneSyncError, laneSynced};
          ADDR_IRQSTAT:  prdata <= {19'h0, irqStatReg};
          ADDR_IRQEN:    prdata <= {19'h0, irqEnReg};
          ADDR_IRQCLR:   prdata <= '0;
          ADDR_LOOPSEL:  prdata <= {20'h0, transceiverLoopbackSelect};
          default:       pslverr <= 1'b1;
        endcase
        if (pwrite)
          prdata <= '0;
      end
    end
  end

endmodule

// ===== bench/pla_lane_partner.sv
// Model of the four transceiver lanes that deliver recovered blocks.
`timescale 1ns/1ps
module pla_lane_partner
(
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  // Bench control
  input  wire logic [63:0]                            noise,
  input  wire logic [15:0]                            spacing,
  input  wire logic [1:0]                             fault,
  // Recovered lanes
  output pla_pkg::pla_blk_t [pla_pkg::LANES-1:0]      rxBlock
);
  import pla_pkg::*;
  int          gap;
  logic [7:0]  acc [LANES];
  logic [7:0]  bip;
  logic [23:0] pat;
  pla_blk_t    b;
  logic        mk;

  // Lane i carries PCS lane i+1, so a map stuck at identity shows up.
  // A fault is applied to the next marker only: 1 early, 2 malformed,
  // 3 wrong parity byte.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap = 0;
      for (int i = 0; i < LANES; i++) acc[i] = 8'h00;
      rxBlock <= '0;
    end
    else
    begin
      mk = gap >= int'(spacing) - int'(fault == 2'h1);
      for (int i = 0; i < LANES; i++)
      begin
        pat = MARKER_PAT[(i + 1) % LANES];
        bip = acc[i] ^ {7'h00, fault == 2'h3};
        b.valid = 1'b1;
        b.header = mk ? HDR_CTRL : HDR_DATA;
        b.payload = mk ? {~bip, ~pat, bip, pat} : noise ^ 64'(i);
        if (mk && fault == 2'h2) b.payload[40] = ~b.payload[40];
        if (mk) acc[i] = 8'h00;
        acc[i] ^= {6'h00, b.header};
        for (int k = 0; k < 8; k++) acc[i] ^= b.payload[8*k +: 8];
        rxBlock[i] <= b;
      end
      gap = mk ? 0 : gap + 1;
    end
  end
endmodule

// ===== bench/test_pla_rx_lane_align.sv
// Self-checking bench for the receive lane aligner.
`timescale 1ns/1ps
module test_pla_rx_lane_align;
  import pla_pkg::*;
  logic                  clk, nrst, psel, penable, pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd, seed;
  logic                  pready, pslverr, irq, er, fmtErr, watch;
  pla_blk_t [LANES-1:0]  rxBlock, txBlock, txOut;
  logic [11:0]           loopSel;
  logic [LANES-1:0][1:0] physMap;
  logic [LANES-1:0]      bipErr, synced, syncErr, intErr, repErr;
  logic [LANES-1:0]      eBip, eInt, eRep;
  logic                  eFmt;
  logic [63:0]           noise;
  logic [15:0]           spacing;
  logic [1:0]            fault;
  int                    badCount, compares;
  int                    mGood [LANES], mGap [LANES], mErr [LANES];
  logic [7:0]            mAcc [LANES];
  logic                  mHad [LANES];

  pla_rx_lane_align i_pla_rx_lane_align (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .rxBlock(rxBlock), .txOut(txOut),
    .transceiverLoopbackSelect(loopSel), .txBlock(txBlock),
    .pcsLanePhysMap(physMap), .laneBipError(bipErr), .laneSynced(synced),
    .laneSyncError(syncErr), .markerIntervalError(intErr),
    .markerRepeatError(repErr), .markerFormatError(fmtErr));
  pla_lane_partner i_pla_lane_partner (.clk(clk), .nrst(nrst),
    .noise(noise), .spacing(spacing), .fault(fault), .rxBlock(rxBlock));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finishTest;
    if (badCount == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(string n, logic [331:0] exp, logic [331:0] got);
    compares++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      badCount++;
      finishTest();
    end
  endtask

  // Waits for the next marker with the given fault, then one more edge
  // so the monitor has compared the pulses that marker caused.
  task automatic marker(logic [1:0] kind);
    int n;
    fault <= kind;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (rxBlock[0].header === HDR_CTRL) break;
    end
    fault <= 2'h0;
    if (n >= 200)
    begin
      badCount++;
      finishTest();
    end
    @(posedge clk);
  endtask

  // Reference model of one lane: lock count, marker spacing, parity.
  task automatic modelLane(int i);
    pla_blk_t b;
    logic     cand, err;
    b = rxBlock[i];
    cand = 1'b0;
    err = 1'b0;
    if (b.valid !== 1'b1) return;
    mGood[i] = (b.header == HDR_DATA || b.header == HDR_CTRL) ?
               mGood[i] + 1 : 0;
    for (int p = 0; p < LANES; p++)
      if (b.header == HDR_CTRL && b.payload[23:0] == MARKER_PAT[p])
        cand = 1'b1;
    if (cand && mGood[i] > 64)
    begin
      if (b.payload[63:32] != ~b.payload[31:0])
      begin
        eFmt = 1'b1;
        err = 1'b1;
      end
      else
      begin
        err = mHad[i] && mGap[i] != int'(spacing);
        eInt[i] = err;
        eBip[i] = mHad[i] && mAcc[i] != b.payload[31:24];
        mHad[i] = 1'b1;
        mGap[i] = -1;
        mAcc[i] = 8'h00;
      end
      mErr[i] = err ? mErr[i] + 1 : 0;
      eRep[i] = mErr[i] == 4;
    end
    mGap[i]++;
    mAcc[i] ^= {6'h00, b.header};
    for (int k = 0; k < 8; k++) mAcc[i] ^= b.payload[8*k +: 8];
  endtask

  always @(posedge clk)
  begin
    noise <= {$random(seed), $random(seed)};
    for (int k = 0; k < LANES; k++)
      txBlock[k] <= 67'({$random(seed), $random(seed), $random(seed)});
    if (!nrst)
      for (int i = 0; i < LANES; i++)
      begin
        mGood[i] = 0;
        mErr[i] = 0;
        mHad[i] = 1'b0;
      end
    else
    begin
      if (watch)
      begin
        check("bipErr", eBip, bipErr);
        check("intErr", eInt, intErr);
        check("repErr", eRep, repErr);
        check("fmtErr", eFmt, fmtErr);
      end
      {eBip, eInt, eRep, eFmt} = '0;
      for (int i = 0; i < LANES; i++) modelLane(i);
    end
  end

  // Mode 1 sends scrambled idles, bit 1 loops the lanes back.
  task automatic txMode(logic [1:0] m);
    pla_blk_t [LANES-1:0] exp;
    logic [63:0]          last;
    last = '0;
    apb(1'b1, ADDR_CTRL, {30'h0, m});
    repeat (2) @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      exp = m[1] ? rxBlock : txBlock;
      @(posedge clk);
      if (m == 2'h1)
      begin
        check("tpHdr", HDR_CTRL, txOut[c].header);
        check("tpScr", 1'b1, txOut[0].payload !== last &&
              txOut[0].payload !== {56'h0, IDLE_TYPE});
        last = txOut[0].payload;
      end
      else check("txPath", exp, txOut);
    end
  endtask

  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, fault} = '0;
    {eBip, eInt, eRep, eFmt, badCount, compares} = '0;
    seed = 32'hA8862C2C;
    noise = '0;
    txBlock = '0;
    spacing = 16'h0050;
    watch = 1'b1;
    repeat (4) @(posedge clk);
    check("rstOut", '0, {synced, syncErr, bipErr, intErr, repErr, fmtErr,
          physMap, irq, pready, pslverr, prdata, txOut});
    nrst <= 1'b1;
    apb(1'b1, ADDR_SPACING, {16'h0, spacing});
    apb(1'b0, ADDR_SPACING, 32'h0);
    check("spacing", spacing, rd);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped", 33'h1_0000_0000, {er, rd});
    apb(1'b1, ADDR_LOOPSEL, 32'(noise[11:0]));
    @(posedge clk);
    check("loopSel", pwdata[11:0], loopSel);
    marker(2'h0);
    marker(2'h0);
    repeat (2) @(posedge clk);
    check("synced", 8'hF0, {synced, syncErr});
    check("physMap", 8'h93, physMap);
    apb(1'b1, ADDR_LANESTAT, 32'hFFFFFFFF);
    apb(1'b0, ADDR_LANESTAT, 32'h0);
    check("laneStat", 20'hF930F, rd[19:0]);
    repeat (4) marker(2'h1);
    marker(2'h0);
    apb(1'b1, ADDR_IRQCLR, 32'h00001FFF);
    marker(2'h3);
    apb(1'b0, ADDR_IRQSTAT, 32'h0);
    check("irqStat", 33'h0_0000_000F, {irq, rd});
    apb(1'b1, ADDR_IRQEN, 32'h0000000F);
    repeat (2) @(posedge clk);
    check("irqOn", 1'b1, irq);
    apb(1'b1, ADDR_IRQCLR, 32'h0000000F);
    repeat (2) @(posedge clk);
    check("irqOff", 1'b0, irq);
    marker(2'h2);
    watch <= 1'b0;
    for (int m = 0; m < 4; m++) txMode(2'(m));
    finishTest();
  end
endmodule
